// ===== design/status_gate_regs.svh
// Register offsets, field positions, reset values and frame counts of the status and mode gate
`ifndef STATUS_GATE_REGS_SVH
`define STATUS_GATE_REGS_SVH

`define ADDR_MODE_CONTROL      8'hC1
`define ADDR_EVENT_STATUS      8'hC6
`define ADDR_PROGRAM_PORT      8'hC8
`define ADDR_EVENT_MASK        8'hCE

`define STATUS_PENDING_BIT     15
`define STATUS_PROG_READY_BIT  0
`define STATUS_SYNTH_BIT       1
`define MASK_MASTER_BIT        15
`define STATUS_STICKY_MASK     15'h7FFC

`define MODE_RESET             2'h0
`define MASK_RESET             16'h0000
`define FLAGS_RESET            15'h0000

`define ADDR_BITS              8
`define WORD_BITS              16
`define ADDR_LAST_BIT          5'h07
`define FRAME_LAST_BIT         5'h17

`endif

// ===== design/status_gate_pkg.sv
// Types shared by the status and mode gate
package status_gate_pkg;

    // Operating mode in the two low bits of the mode register
    typedef enum logic [1:0] {
        MODE_IDLE     = 2'h0,
        MODE_RECEIVE  = 2'h1,
        MODE_TRANSMIT = 2'h2,
        MODE_RESERVED = 2'h3
    } op_mode_t;

    // Serial frame sequencer, one-hot
    typedef enum logic [3:0] {
        FRAME_ADDR  = 4'h1,
        FRAME_WRITE = 4'h2,
        FRAME_READ  = 4'h4,
        FRAME_SKIP  = 4'h8
    } frame_state_t;

    // Clock control defaults held in the third program block
    typedef struct packed {
        logic [7:0] slow_setting;
        logic [7:0] fast_setting;
    } clock_defaults_t;

    // Word handed to the program-block loader
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } program_word_t;

endpackage

// ===== design/status_interrupt_and_mode_gate.sv
// Status flags, interrupt line, mode register and program port behind the serial control bus
`include "status_gate_regs.svh"

module status_interrupt_and_mode_gate
    import status_gate_pkg::*;
(
    input  wire logic            clk_sys_in,
    input  wire logic            reset_n_in,
    input  wire logic            select_n_in,
    input  wire logic            serial_clock_in,
    input  wire logic            command_data_in,
    output logic                 reply_data_out,
    output logic                 reply_enable_out,
    output logic                 host_alert_n_out,
    input  wire logic [14:2]     event_set_in,
    input  wire logic            synth_channel_flag_in,
    input  wire clock_defaults_t clock_defaults_in,
    output program_word_t        program_word_out,
    input  wire logic            program_taken_in,
    output op_mode_t             mode_out,
    output logic                 fast_clock_out,
    output logic [7:0]           clock_setting_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic         select_s1;
    logic         select_s2;
    logic         sclk_s1;
    logic         sclk_s2;
    logic         sclk_s3;
    logic         data_s1;
    logic         data_s2;

    // Two flops on every pin; the third clock flop only feeds edge detection
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            select_s1 <= 1'b1;
            select_s2 <= 1'b1;
            sclk_s1   <= 1'b1; // Idle high, so no false edge after reset
            sclk_s2   <= 1'b1;
            sclk_s3   <= 1'b1;
            data_s1   <= 1'b0;
            data_s2   <= 1'b0;
        end else begin
            select_s1 <= select_n_in;
            select_s2 <= select_s1;
            sclk_s1   <= serial_clock_in;
            sclk_s2   <= sclk_s1;
            sclk_s3   <= sclk_s2;
            data_s1   <= command_data_in;
            data_s2   <= data_s1;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    assign sclk_rise = sclk_s2 & ~sclk_s3 & ~select_s2;
    assign sclk_fall = ~sclk_s2 & sclk_s3 & ~select_s2;

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame: 8 address bits then 16 data bits, MSB first

    frame_state_t state;
    logic [4:0]   bit_count;
    logic [14:0]  shift_in;
    logic [7:0]   addr_now;
    logic [15:0]  word_now;
    logic [7:0]   write_addr;
    logic         addr_done;
    logic         write_done;
    logic         status_read;

    assign addr_now    = {shift_in[6:0], data_s2};
    assign word_now    = {shift_in, data_s2};
    assign addr_done   = sclk_rise && (state == FRAME_ADDR) && (bit_count == `ADDR_LAST_BIT);
    assign write_done  = sclk_rise && (state == FRAME_WRITE) && (bit_count == `FRAME_LAST_BIT);
    assign status_read = addr_done && (addr_now == `ADDR_EVENT_STATUS);

    // Deselect always restarts the frame, so a torn frame writes nothing
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state      <= FRAME_ADDR;
            bit_count  <= 5'h00;
            shift_in   <= 15'h0000;
            write_addr <= 8'h00;
        end else if (select_s2) begin
            state     <= FRAME_ADDR;
            bit_count <= 5'h00;
        end else if (sclk_rise) begin
            shift_in  <= word_now[14:0];
            bit_count <= (bit_count == `FRAME_LAST_BIT) ? bit_count : bit_count + 5'h01;
            case (state)
                FRAME_ADDR: begin
                    if (bit_count == `ADDR_LAST_BIT) begin
                        write_addr <= addr_now;
                        // Unlisted addresses are swallowed without effect
                        if (addr_now == `ADDR_EVENT_STATUS) begin
                            state <= FRAME_READ;
                        end else if (addr_now == `ADDR_MODE_CONTROL || addr_now == `ADDR_PROGRAM_PORT ||
                                     addr_now == `ADDR_EVENT_MASK) begin
                            state <= FRAME_WRITE;
                        end else begin
                            state <= FRAME_SKIP;
                        end
                    end
                end
                FRAME_WRITE: begin
                    if (bit_count == `FRAME_LAST_BIT) begin
                        state <= FRAME_SKIP;
                    end
                end
                FRAME_READ: begin
                    state <= FRAME_READ;
                end
                default: begin
                    state <= FRAME_SKIP;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode register and clock speed

    // Reserved code is stored but keeps the slow clock
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_out <= op_mode_t'(`MODE_RESET);
        end else if (write_done && write_addr == `ADDR_MODE_CONTROL) begin
            mode_out <= op_mode_t'(word_now[1:0]);
        end
    end

    // Speed follows the mode register with no host step
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fast_clock_out    <= 1'b0;
            clock_setting_out <= 8'h00;
        end else begin
            fast_clock_out    <= (mode_out == MODE_RECEIVE) || (mode_out == MODE_TRANSMIT);
            clock_setting_out <= fast_clock_out ? clock_defaults_in.fast_setting
                                                : clock_defaults_in.slow_setting;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program port, open only in idle

    logic program_ready;
    assign program_ready = (mode_out == MODE_IDLE) && !program_word_out.valid;

    // A write while not ready is dropped rather than overwriting a waiting word
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            program_word_out <= '0;
        end else if (write_done && write_addr == `ADDR_PROGRAM_PORT && program_ready) begin
            program_word_out.valid <= 1'b1;
            program_word_out.data  <= word_now;
        end else if (program_taken_in) begin
            program_word_out.valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mask register

    logic [15:0] mask;
    logic [15:0] next_mask;
    assign next_mask = (write_done && write_addr == `ADDR_EVENT_MASK) ? word_now : mask;

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mask <= `MASK_RESET;
        end else begin
            mask <= next_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags and pending bit

    logic [14:0] flags;
    logic [14:0] next_flags;
    logic [14:0] flags_after_clear;
    logic [14:0] flag_rise;
    logic        pending;
    logic        pending_set;

    // Sticky flags: set beats the read clear; bits 0 and 1 are live levels
    always_comb begin
        flags_after_clear = status_read ? (flags & ~`STATUS_STICKY_MASK) : flags;
        next_flags        = flags_after_clear | ({event_set_in, 2'b00} & `STATUS_STICKY_MASK);
        next_flags[`STATUS_PROG_READY_BIT] = program_ready;
        next_flags[`STATUS_SYNTH_BIT]      = synth_channel_flag_in;
        flag_rise         = next_flags & ~flags_after_clear;
    end

    // Compared against post-clear flags so a same-cycle event still raises pending
    assign pending_set = |(flag_rise & next_mask[14:0])
                       | |(next_mask[14:0] & ~mask[14:0] & next_flags);

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flags   <= `FLAGS_RESET;
            pending <= 1'b0;
        end else begin
            flags   <= next_flags;
            pending <= pending_set ? 1'b1 : (status_read ? 1'b0 : pending);
        end
    end

    assign host_alert_n_out = ~(pending & mask[`MASK_MASTER_BIT]);

    ////////////////////////////////////////////////////////////////////////////
    // Reply shifter for status reads

    logic [15:0] reply_shift;

    // Snapshot taken before the clear lands; bits move out on serial clock falls
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reply_shift      <= 16'h0000;
            reply_data_out   <= 1'b0;
            reply_enable_out <= 1'b0;
        end else if (select_s2) begin
            reply_enable_out <= 1'b0;
        end else if (status_read) begin
            reply_shift      <= {pending, flags};
            reply_enable_out <= 1'b1;
        end else if (sclk_fall && state == FRAME_READ) begin
            reply_data_out <= reply_shift[`WORD_BITS-1];
            reply_shift    <= {reply_shift[14:0], 1'b0};
        end
    end

endmodule // status_interrupt_and_mode_gate

// ===== sim/status_gate_props.sv
// Port-level assertions for the status and mode gate
module status_gate_props
    import status_gate_pkg::*;
(
    input wire logic            clk_sys_in,
    input wire logic            reset_n_in,
    input wire logic            select_n_in,
    input wire logic            host_alert_n_out,
    input wire logic            reply_enable_out,
    input wire clock_defaults_t clock_defaults_in,
    input wire program_word_t   program_word_out,
    input wire logic            program_taken_in,
    input wire op_mode_t        mode_out,
    input wire logic            fast_clock_out,
    input wire logic [7:0]      clock_setting_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    ////////////////////////////////////////////////////////////////
    // Clock speed follows the mode one cycle later
    a_fast_mode: assert property (fast_clock_out == ($past(mode_out) inside {MODE_RECEIVE, MODE_TRANSMIT}))
        else $error("fast flag does not follow mode");
    a_speed_setting: assert property ($past(reset_n_in) |-> clock_setting_out == ($past(fast_clock_out) ?
        $past(clock_defaults_in.fast_setting) : $past(clock_defaults_in.slow_setting)))
        else $error("clock setting wrong");
    // Mode only moves inside a frame; select is low in that cycle and the one before
    a_mode_frame: assert property ($changed(mode_out) |-> !select_n_in && !$past(select_n_in))
        else $error("mode changed outside a frame");

    ////////////////////////////////////////////////////////////////
    // Alert is only withdrawn by bus traffic
    a_alert_kept: assert property (select_n_in [*5] ##0 !host_alert_n_out |=> !host_alert_n_out)
        else $error("alert dropped without a frame");
    a_reply_quiet: assert property (select_n_in [*6] |-> !reply_enable_out)
        else $error("reply driven outside a frame");

    ////////////////////////////////////////////////////////////////
    // Program word handshake
    a_word_held: assert property (program_word_out.valid && !program_taken_in |=>
        program_word_out.valid && $stable(program_word_out.data)) else $error("program word not held");
    a_word_taken: assert property (program_word_out.valid && program_taken_in |=> !program_word_out.valid)
        else $error("program word not released");
    a_word_idle: assert property ($rose(program_word_out.valid) |-> mode_out == MODE_IDLE && !select_n_in)
        else $error("program word accepted outside idle");
endmodule // status_gate_props

// ===== sim/host_model.sv
// Host side of the serial control bus
module host_model (
    input  wire logic clk_in,
    input  wire logic reply_data_in,
    input  wire logic reply_enable_in,
    output logic      select_n_out,
    output logic      serial_clock_out,
    output logic      command_data_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // Serial clock rests high between frames
    initial begin
        select_n_out = 1'b1;
        serial_clock_out = 1'b1;
        command_data_out = 1'b0;
    end

    // One frame, MSB first; reply sampled just before each rise
    task automatic xfer(input logic [7:0] a, input logic [15:0] w, output logic [15:0] r, output logic en);
        logic [23:0] f;
        f = {a, w};
        r = '0;
        en = 1'b0;
        select_n_out = 1'b0;
        repeat (4) @(negedge clk_in);
        for (int i = 23; i >= 0; i--) begin
            serial_clock_out = 1'b0;
            command_data_out = f[i];
            repeat (8) @(negedge clk_in);
            r = {r[14:0], reply_enable_in ? reply_data_in : ~r[0]};  // Undriven line drifts
            en = en | reply_enable_in;
            serial_clock_out = 1'b1;
            repeat (8) @(negedge clk_in);
        end
        select_n_out = 1'b1;
        command_data_out = ~command_data_out;  // Released line, no pull
        repeat (6) @(negedge clk_in);
    endtask
endmodule // host_model

// ===== sim/test_status_interrupt_and_mode_gate.sv
// Testbench of the status and mode gate
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end

module test_status_interrupt_and_mode_gate
    import status_gate_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic            clk = 1'b0;
    logic            reset_n = 1'b0;
    logic            sel_n;
    logic            sclk;
    logic            cmd;
    logic            reply;
    logic            reply_en;
    logic            alert_n;
    logic [14:2]     ev = '0;
    logic            synth = 1'b0;
    clock_defaults_t dflt = 16'h1199;
    program_word_t   pw;
    logic            taken = 1'b0;
    op_mode_t        mode;
    logic            fast;
    logic [7:0]      setting;
    logic [15:0]     st;
    logic            en;
    int              err_count = 0;
    int              n_checks = 0;

    always #5 clk = ~clk;

    status_interrupt_and_mode_gate dut (.clk_sys_in(clk), .reset_n_in(reset_n), .select_n_in(sel_n),
        .serial_clock_in(sclk), .command_data_in(cmd), .reply_data_out(reply), .reply_enable_out(reply_en),
        .host_alert_n_out(alert_n), .event_set_in(ev), .synth_channel_flag_in(synth),
        .clock_defaults_in(dflt), .program_word_out(pw), .program_taken_in(taken), .mode_out(mode),
        .fast_clock_out(fast), .clock_setting_out(setting));
    host_model host (.clk_in(clk), .reply_data_in(reply), .reply_enable_in(reply_en),
        .select_n_out(sel_n), .serial_clock_out(sclk), .command_data_out(cmd));

    ////////////////////////////////////////////////////////////////
    // Bus and event helpers
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] r;
        logic e;
        host.xfer(a, d, r, e);
    endtask
    task automatic rd(input logic [15:0] e);
        host.xfer(8'hC6, 16'h0000, st, en);
        `CHK("status", e, st)
        `CHK("reply on", 1'b1, en)
    endtask
    task automatic pulse(input logic [14:2] v);
        ev = v;
        @(negedge clk);
        ev = '0;
    endtask
    task automatic test_done();
        if (err_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        `CHK("alert", 1'b1, alert_n)
        rd(16'h0001);
        wr(8'hCE, 16'h8020);
        pulse(13'h008);
        `CHK("alert", 1'b0, alert_n)
        rd(16'h8021);
        `CHK("alert", 1'b1, alert_n)
        rd(16'h0001);
        pulse(13'h020);
        `CHK("alert", 1'b1, alert_n)
        wr(8'hCE, 16'h80A0);
        `CHK("alert", 1'b0, alert_n)
        synth = 1'b1;
        rd(16'h8083);
        rd(16'h0003);
        wr(8'hCE, 16'h8000);
        pulse(13'h1FFF);
        rd(16'h7FFF);
        // Event on the clearing edge: 126 falls in, the 8th rise is just through the synchroniser
        fork
            rd(16'h0003);
            begin
                repeat (126) @(negedge clk);
                pulse(13'h001);
            end
        join
        rd(16'h0007);
        for (int m = 3; m >= 0; m--) begin
            wr(8'hC1, 16'(m));
            `CHK("mode", 2'(m), mode)
            `CHK("fast", m == 1 || m == 2, fast)
            `CHK("setting", (m == 1 || m == 2) ? 8'h99 : 8'h11, setting)
        end
        wr(8'hC1, 16'h0001);
        wr(8'hC8, 16'h1234);
        `CHK("word refused", 1'b0, pw.valid)
        wr(8'hC1, 16'h0000);  // Idle before program access
        wr(8'hC8, 16'h1234);  // Written while ready
        `CHK("word", 17'h11234, pw)
        rd(16'h0002);
        taken = 1'b1;
        @(negedge clk);
        taken = 1'b0;
        rd(16'h0003);
        host.xfer(8'hC4, 16'h0002, st, en);
        `CHK("no reply", 1'b0, en)
        `CHK("mode kept", MODE_IDLE, mode)
        test_done();
    end

    // Watchdog: about twenty-two frames of four hundred cycles, more than doubled
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule // test_status_interrupt_and_mode_gate

bind status_interrupt_and_mode_gate status_gate_props props (.clk_sys_in, .reset_n_in, .select_n_in,
    .host_alert_n_out, .reply_enable_out, .clock_defaults_in, .program_word_out, .program_taken_in,
    .mode_out, .fast_clock_out, .clock_setting_out);
